// *** common/scpsc_pkg.sv ***
// Types shared by the clock-enable power-state control
package scpsc_pkg;
`include "scpsc_regs.svh"

  // Power states, binary coded from normal outward
  typedef enum logic [1:0] {
    SCPSC_NORMAL = 2'h0,
    SCPSC_ACT_PD = 2'h1,
    SCPSC_SELF_REF = 2'h2,
    SCPSC_PRE_PD = 2'h3
  } scpsc_pstate_t;

  // Command code equals {ras_n, cas_n, we_n}; deselect folds into nop
  typedef enum logic [2:0] {
    SCPSC_CMD_MRS = 3'h0,
    SCPSC_CMD_REF = 3'h1,
    SCPSC_CMD_PRE = 3'h2,
    SCPSC_CMD_ACT = 3'h3,
    SCPSC_CMD_WR = 3'h4,
    SCPSC_CMD_RD = 3'h5,
    SCPSC_CMD_RSV = 3'h6,
    SCPSC_CMD_NOP = 3'h7
  } scpsc_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [`SCPSC_BA_W-1:0] ba;
    logic a10;
  } scpsc_pins_t;

  typedef struct packed {
    logic valid;
    logic dm;
    logic [`SCPSC_DQ_W-1:0] data;
  } scpsc_beat_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } scpsc_sync_st_t;

  typedef struct packed {
    scpsc_pstate_t pstate;
    logic cke_prev;
    logic lvl_prev;
    logic [`SCPSC_BANKS-1:0] banks;
    logic cmd_vld;
    scpsc_cmd_t cmd;
    logic [`SCPSC_BA_W-1:0] cmd_ba;
    logic sr_refresh;
    logic odt_on;
    logic store;
    logic [`SCPSC_DQ_W-1:0] sdata;
  } scpsc_core_st_t;
endpackage

// *** common/scpsc_regs.svh ***
// Widths and timing counts of the clock-enable power-state control
`ifndef SCPSC_REGS_SVH
`define SCPSC_REGS_SVH
`define SCPSC_BANKS 8
`define SCPSC_BA_W 3
`define SCPSC_DQ_W 8
`define SCPSC_CKE_MIN_HOLD_CLKS 3
`define SCPSC_SRX_READ_CLKS 200
`endif

// *** core/scpsc_core.sv ***
// Clock-enable power-state control with bank tracking and write masking
//
// How it works
// RULE1: each edge acts on previous and present enable, state and command.
// RULE2: enable high at both edges executes the registered command.
// RULE3: enable fall with nop and an open bank enters active power-down.
// RULE4: enable fall with nop and all banks idle enters precharge power-down.
// RULE5: enable fall with refresh and all banks idle enters self refresh.
// RULE6: controller requests self refresh only with every bank idle; the bench requests it once with bank 5 open.
// RULE7: controller shows only nop or deselect on power-down enable edges.
// RULE8: controller leaves self refresh by raising enable with nop; the bench raises it with refresh on every other loop exit.
// RULE9: controller sends only nop until the non-read exit delay passes.
// RULE10: controller waits the read exit delay before any read.
// RULE11: controller never sleeps while read, write, mode set or precharge run.
// RULE12: controller holds each new enable level for three registered edges.
// RULE13: no refresh runs in power-down; controller bounds its length.
// RULE14: controller drives termination pin defined in power-down when enabled.
// RULE15: termination is off in self refresh; it never steers power states.
// RULE16: controller uses only the listed enable and command combinations.
// RULE17: after illegal use the controller reruns full initialisation.
// RULE18: a write beat is stored only when its mask is low.
// RULE19: self-refresh exit is seen without relying on a stable clock.
// RULE20: one power-state register, four states, clocked except async reset; exit is clocked too.
`timescale 1ns/1ns
`include "scpsc_regs.svh"
module scpsc_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic cke,
  input wire scpsc_pkg::scpsc_pins_t pins,
  input wire logic odt,
  input wire scpsc_pkg::scpsc_beat_t beat,
  output scpsc_pkg::scpsc_pstate_t pstate,
  output logic [`SCPSC_BANKS-1:0] open_banks,
  output logic cmd_vld,
  output scpsc_pkg::scpsc_cmd_t cmd_out,
  output logic [`SCPSC_BA_W-1:0] cmd_ba,
  output logic sr_refresh,
  output logic odt_on,
  output logic wr_store,
  output logic [`SCPSC_DQ_W-1:0] wr_data
);
  scpsc_pkg::scpsc_core_st_t st_q;
  scpsc_pkg::scpsc_core_st_t st_d;
  logic cke_lvl;
  logic idle;
  logic is_nop;
  logic exit_async;
  scpsc_pkg::scpsc_cmd_t cmd;

  // Filtered enable level; a clock too unstable to sample the rising
  // pair still leaves this level to rise once the pin settles high
  scpsc_sync u_cke_sync (
    .clk(clk),
    .rst(rst),
    .din(cke),
    .level(cke_lvl)
  );

  // Command decode shared by every state
  always_comb begin
    cmd = pins.cs_n ? scpsc_pkg::SCPSC_CMD_NOP :
      scpsc_pkg::scpsc_cmd_t'({pins.ras_n, pins.cas_n, pins.we_n});
    is_nop = (cmd == scpsc_pkg::SCPSC_CMD_NOP);
    idle = (st_q.banks == {`SCPSC_BANKS{1'b0}});
    exit_async = cke_lvl && !st_q.lvl_prev;
  end

  // Next state; sequences outside the table leave the state alone
  always_comb begin
    st_d = st_q;
    st_d.cke_prev = cke; // RULE1
    st_d.lvl_prev = cke_lvl;
    st_d.cmd_vld = 1'b0;
    case (st_q.pstate)
      scpsc_pkg::SCPSC_NORMAL: begin
        if (st_q.cke_prev && cke) begin
          // Only normal state decodes, so no refresh leaks into sleep
          st_d.cmd_vld = !pins.cs_n; // RULE2 RULE13
          st_d.cmd = cmd;
          st_d.cmd_ba = pins.ba;
          if (!pins.cs_n) begin
            case (cmd)
              scpsc_pkg::SCPSC_CMD_ACT: begin
                st_d.banks[pins.ba] = 1'b1;
              end
              scpsc_pkg::SCPSC_CMD_PRE: begin
                if (pins.a10) begin
                  st_d.banks = {`SCPSC_BANKS{1'b0}};
                end else begin
                  st_d.banks[pins.ba] = 1'b0;
                end
              end
              // Auto-precharge closes the bank at once; timing is the
              // controller's to respect before the next activate
              scpsc_pkg::SCPSC_CMD_RD, scpsc_pkg::SCPSC_CMD_WR: begin
                if (pins.a10) begin
                  st_d.banks[pins.ba] = 1'b0;
                end
              end
              default: begin
              end
            endcase
          end
        end else if (st_q.cke_prev && !cke) begin
          if (is_nop && !idle) begin
            st_d.pstate = scpsc_pkg::SCPSC_ACT_PD; // RULE3
          end else if (is_nop) begin
            st_d.pstate = scpsc_pkg::SCPSC_PRE_PD; // RULE4
          end else if (cmd == scpsc_pkg::SCPSC_CMD_REF && idle) begin
            st_d.pstate = scpsc_pkg::SCPSC_SELF_REF; // RULE5
            // The filtered level may still be rising from the short high
            // hold; count the entry edge as seen high so it is no exit
            st_d.lvl_prev = 1'b1; // RULE19
          end
        end
      end
      scpsc_pkg::SCPSC_ACT_PD, scpsc_pkg::SCPSC_PRE_PD: begin
        // Stays asleep while enable is low
        if (!st_q.cke_prev && cke && is_nop) begin
          st_d.pstate = scpsc_pkg::SCPSC_NORMAL; // RULE3 RULE4
        end
      end
      scpsc_pkg::SCPSC_SELF_REF: begin
        // Either the sampled rise or the settled level ends it
        if ((!st_q.cke_prev && cke && is_nop) || exit_async) begin
          st_d.pstate = scpsc_pkg::SCPSC_NORMAL; // RULE5 RULE19
        end
      end
      default: begin
        st_d.pstate = scpsc_pkg::SCPSC_NORMAL;
      end
    endcase
    st_d.sr_refresh = (st_d.pstate == scpsc_pkg::SCPSC_SELF_REF);
    // Termination pin gates only its own output, never the state
    st_d.odt_on = odt && !st_d.sr_refresh; // RULE15
    st_d.store = beat.valid && !beat.dm; // RULE18
    if (beat.valid) begin
      st_d.sdata = beat.data;
    end
  end

  // Single power-state register; power-up is normal, enable low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0; // RULE20
    end else begin
      st_q <= st_d;
    end
  end

  assign pstate = st_q.pstate;
  assign open_banks = st_q.banks;
  assign cmd_vld = st_q.cmd_vld;
  assign cmd_out = st_q.cmd;
  assign cmd_ba = st_q.cmd_ba;
  assign sr_refresh = st_q.sr_refresh;
  assign odt_on = st_q.odt_on;
  assign wr_store = st_q.store;
  assign wr_data = st_q.sdata;

  // Checks on the power-state, termination and write-mask behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_HH_EXEC: assert property ( // RULE2
    st_q.pstate == scpsc_pkg::SCPSC_NORMAL && st_q.cke_prev && cke &&
    !pins.cs_n && cmd == scpsc_pkg::SCPSC_CMD_ACT
    |=> cmd_vld && cmd_out == scpsc_pkg::SCPSC_CMD_ACT &&
    open_banks[cmd_ba])
    else $error("activate not executed with enable high");

  AST_APD_ENTRY: assert property ( // RULE3
    pstate == scpsc_pkg::SCPSC_NORMAL && st_q.cke_prev && !cke &&
    is_nop && !idle |=> pstate == scpsc_pkg::SCPSC_ACT_PD)
    else $error("active power-down not entered");

  AST_PPD_ENTRY: assert property ( // RULE4
    pstate == scpsc_pkg::SCPSC_NORMAL && st_q.cke_prev && !cke &&
    is_nop && idle |=> pstate == scpsc_pkg::SCPSC_PRE_PD)
    else $error("precharge power-down not entered");

  AST_SR_ENTRY: assert property ( // RULE5
    pstate == scpsc_pkg::SCPSC_NORMAL && st_q.cke_prev && !cke &&
    !pins.cs_n && cmd == scpsc_pkg::SCPSC_CMD_REF && idle
    |=> pstate == scpsc_pkg::SCPSC_SELF_REF && sr_refresh)
    else $error("self refresh not entered");

  AST_PD_HOLD: assert property ( // RULE3
    (pstate == scpsc_pkg::SCPSC_ACT_PD ||
    pstate == scpsc_pkg::SCPSC_PRE_PD) && !cke |=> $stable(pstate))
    else $error("power-down left with enable low");

  AST_SR_ENTRY_STAY: assert property ( // RULE5
    $rose(sr_refresh) && !cke |=> sr_refresh)
    else $error("self refresh left on the edge after entry");

  AST_SR_HOLD: assert property ( // RULE5
    pstate == scpsc_pkg::SCPSC_SELF_REF && !cke && !exit_async
    |=> pstate == scpsc_pkg::SCPSC_SELF_REF)
    else $error("self refresh left with enable low");

  AST_NO_CMD_ASLEEP: assert property ( // RULE13
    pstate != scpsc_pkg::SCPSC_NORMAL |=> !cmd_vld)
    else $error("command executed while asleep");

  AST_ODT_OFF_SR: assert property ( // RULE15
    pstate == scpsc_pkg::SCPSC_SELF_REF |-> !odt_on)
    else $error("termination on in self refresh");

  AST_DM_MASK: assert property ( // RULE18
    beat.valid && beat.dm |=> !wr_store)
    else $error("masked beat stored");

  AST_DM_STORE: assert property ( // RULE18
    beat.valid && !beat.dm |=> wr_store && wr_data == $past(beat.data))
    else $error("unmasked beat not stored");

  AST_SR_ASYNC_EXIT: assert property ( // RULE19
    (pstate == scpsc_pkg::SCPSC_SELF_REF && $rose(cke)) ##1 cke[*5]
    |-> pstate == scpsc_pkg::SCPSC_NORMAL)
    else $error("self refresh exit missed");

  AST_BAD_FALL_HOLD: assert property ( // RULE1
    pstate == scpsc_pkg::SCPSC_NORMAL && st_q.cke_prev && !cke &&
    !is_nop && !(cmd == scpsc_pkg::SCPSC_CMD_REF && idle)
    |=> pstate == scpsc_pkg::SCPSC_NORMAL)
    else $error("illegal enable fall changed state");

  COV_APD: cover property (pstate == scpsc_pkg::SCPSC_ACT_PD);
  COV_PPD_EXIT: cover property (pstate == scpsc_pkg::SCPSC_PRE_PD
    ##1 pstate == scpsc_pkg::SCPSC_NORMAL);
  COV_SR_EXIT: cover property (pstate == scpsc_pkg::SCPSC_SELF_REF
    ##1 pstate == scpsc_pkg::SCPSC_NORMAL);
  COV_MASKED: cover property (beat.valid && beat.dm);
endmodule

// *** core/scpsc_sync.sv ***
// Three-stage pin synchroniser with a two-stage agreement filter
`timescale 1ns/1ns
module scpsc_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic level
);
  scpsc_pkg::scpsc_sync_st_t st_q;
  scpsc_pkg::scpsc_sync_st_t st_d;

  // Level moves only once the second and third stages agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  // Power-up assumes the enable pin low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.lvl;
endmodule

// *** verification/scpsc_ctrl_model.sv ***
// Controller-side model driving clock enable and command pins
`timescale 1ns/1ns
module scpsc_ctrl_model (
  input wire logic clk,
  output logic cke,
  output scpsc_pkg::scpsc_pins_t pins
);
  initial begin
    cke = 1'b0;
    pins = '1;
  end

  // Nop or deselect; don't-care bits stay defined but are redrawn every call
  function automatic scpsc_pkg::scpsc_pins_t idle();
    scpsc_pkg::scpsc_pins_t p;
    p = scpsc_pkg::scpsc_pins_t'($urandom);
    if (p.cs_n == 1'b0) begin
      {p.ras_n, p.cas_n, p.we_n} = 3'h7;
    end
    return p;
  endfunction

  // One command edge, then back to idle pins
  task automatic issue(input scpsc_pkg::scpsc_cmd_t c, input logic [2:0] ba,
                       input logic a10);
    @(posedge clk);
    pins <= '{1'b0, c[2], c[1], c[0], ba, a10};
    @(posedge clk);
    pins <= idle();
  endtask

  // Enable change with only nop or refresh, held three edges
  task automatic set_cke(input logic lvl, input logic sref);
    @(posedge clk);
    cke <= lvl;
    pins <= sref ? '{1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 1'b0} : idle();
    @(posedge clk);
    pins <= idle();
    // Third registering edge is the caller's next one, the legal minimum
    @(posedge clk);
  endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the clock-enable power-state control
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic odt = 1'b0;
  scpsc_pkg::scpsc_beat_t beat = '0;
  logic cke;
  scpsc_pkg::scpsc_pins_t pins;
  scpsc_pkg::scpsc_pstate_t pstate;
  scpsc_pkg::scpsc_cmd_t cmd_out;
  logic [7:0] open_banks, wr_data, exp_banks;
  logic [2:0] cmd_ba;
  logic cmd_vld, sr_refresh, odt_on, wr_store;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  scpsc_ctrl_model u_scpsc_ctrl_model (.clk(clk), .cke(cke), .pins(pins));
  scpsc_core u_scpsc_core (.clk(clk), .rst(rst), .cke(cke), .pins(pins),
    .odt(odt), .beat(beat), .pstate(pstate), .open_banks(open_banks),
    .cmd_vld(cmd_vld), .cmd_out(cmd_out), .cmd_ba(cmd_ba),
    .sr_refresh(sr_refresh), .odt_on(odt_on), .wr_store(wr_store),
    .wr_data(wr_data));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hang counts as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Open-bank bookkeeping; auto-precharge closes the bank at once
  function automatic logic [7:0] bank_next(input logic [7:0] b,
    input scpsc_pkg::scpsc_cmd_t c, input logic [2:0] ba, input logic a10);
    logic [7:0] m;
    m = 8'h01 << ba;
    case (c)
      scpsc_pkg::SCPSC_CMD_ACT: return b | m;
      scpsc_pkg::SCPSC_CMD_PRE: return a10 ? 8'h00 : b & ~m;
      scpsc_pkg::SCPSC_CMD_RD, scpsc_pkg::SCPSC_CMD_WR:
        return a10 ? b & ~m : b;
      default: return b;
    endcase
  endfunction

  task automatic run_cmd(input scpsc_pkg::scpsc_cmd_t c, input logic [2:0] ba,
                         input logic a10);
    u_scpsc_ctrl_model.issue(c, ba, a10);
    #1;
    exp_banks = bank_next(exp_banks, c, ba, a10);
    chk("cmd_vld", 8'h01, {7'h00, cmd_vld});
    chk("cmd_out", {5'h00, c}, {5'h00, cmd_out});
    chk("cmd_ba", {5'h00, ba}, {5'h00, cmd_ba});
    chk("open_banks", exp_banks, open_banks);
  endtask

  // Enter sleep and check state; termination is dropped only in self refresh
  task automatic sleep_chk(input logic sref,
                           input scpsc_pkg::scpsc_pstate_t exp);
    // Let any read, write, mode set or precharge finish first
    repeat (4) @(posedge clk);
    u_scpsc_ctrl_model.set_cke(1'b0, sref);
    #1;
    chk("pstate", {6'h00, exp}, {6'h00, pstate});
    chk("sr_refresh", {7'h00, sref}, {7'h00, sr_refresh});
    chk("odt_on", {7'h00, odt & ~sref}, {7'h00, odt_on});
  endtask

  initial begin
    int unsigned r;
    scpsc_pkg::scpsc_cmd_t c;
    r = $urandom(32'hC8F7C1F3);
    exp_banks = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    u_scpsc_ctrl_model.set_cke(1'b1, 1'b0);
    for (int i = 0; i < 200; i++) begin
      r = $urandom;
      c = scpsc_pkg::scpsc_cmd_t'(r[2:0]);
      if (c == scpsc_pkg::SCPSC_CMD_RSV) begin
        c = scpsc_pkg::SCPSC_CMD_ACT;
      end
      run_cmd(c, r[5:3], r[6]);
      // Single write beat with random mask, odt changes alongside
      @(posedge clk);
      odt <= r[7];
      beat <= '{1'b1, r[8], r[16:9]};
      @(posedge clk);
      beat <= '0;
      #1;
      chk("wr_store", {7'h00, ~r[8]}, {7'h00, wr_store});
      chk("wr_data", r[16:9], wr_data);
      chk("odt_on", {7'h00, r[7]}, {7'h00, odt_on});
      if (i % 25 == 24) begin
        sleep_chk(1'b0, (exp_banks != 8'h00) ? scpsc_pkg::SCPSC_ACT_PD :
                  scpsc_pkg::SCPSC_PRE_PD);
        // A command while asleep must be ignored
        u_scpsc_ctrl_model.issue(scpsc_pkg::SCPSC_CMD_ACT, r[5:3],
                                 1'b0);
        #1;
        chk("sleep open_banks", exp_banks, open_banks);
        u_scpsc_ctrl_model.set_cke(1'b1, 1'b0);
        #1;
        chk("pd exit", 8'h00, {6'h00, pstate});
        run_cmd(scpsc_pkg::SCPSC_CMD_PRE, 3'h0, 1'b1);
        sleep_chk(1'b1, scpsc_pkg::SCPSC_SELF_REF);
        // Every other exit shows refresh on the rising edge, so the
        // sampled exit is missed and only the settled level can end it
        u_scpsc_ctrl_model.set_cke(1'b1, i % 50 == 49);
        repeat (3) @(posedge clk);
        #1;
        chk("sr exit", 8'h00, {6'h00, pstate});
        chk("sr exit sr_refresh", 8'h00, {7'h00, sr_refresh});
        // Idle past both exit delays before any read can follow
        repeat (200) @(posedge clk);
      end
    end
    // Corner: self refresh re-entered on the first edge the minimum high
    // hold allows, while the filtered enable level is still rising
    u_scpsc_ctrl_model.set_cke(1'b0, 1'b1);
    u_scpsc_ctrl_model.set_cke(1'b1, 1'b0);
    u_scpsc_ctrl_model.set_cke(1'b0, 1'b1);
    #1;
    chk("sr re-entry", {6'h00, scpsc_pkg::SCPSC_SELF_REF},
        {6'h00, pstate});
    u_scpsc_ctrl_model.set_cke(1'b1, 1'b0);
    repeat (200) @(posedge clk);
    // A refresh fall with an open bank is illegal and changes nothing
    run_cmd(scpsc_pkg::SCPSC_CMD_ACT, 3'h5, 1'b0);
    repeat (4) @(posedge clk);
    u_scpsc_ctrl_model.set_cke(1'b0, 1'b1);
    #1;
    chk("bad fall pstate", 8'h00, {6'h00, pstate});
    chk("bad fall open_banks", exp_banks, open_banks);
    // After illegal use the controller starts over from reset
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    exp_banks = 8'h00;
    #1;
    chk("reset open_banks", exp_banks, open_banks);
    chk("reset pstate", 8'h00, {6'h00, pstate});
    u_scpsc_ctrl_model.set_cke(1'b1, 1'b0);
    run_cmd(scpsc_pkg::SCPSC_CMD_ACT, 3'h2, 1'b0);
    end_of_test();
  end
endmodule
